// ===== rtl/smwm_defines.svh
// Register numbers, status bit positions and timing constants of the motion window monitor
`ifndef SMWM_DEFINES_SVH
`define SMWM_DEFINES_SVH
`define SMWM_REG_BASE 16'h0091
`define SMWM_REG_WORDS 38
`define SMWM_IDX_W 6
`define SMWM_PNU_THERMAL_TIME 16'h0091
`define SMWM_PNU_LINES_REV 16'h0095
`define SMWM_PNU_MAX_SPEED 16'h0097
`define SMWM_PNU_RAMP_ACCEL 16'h009b
`define SMWM_PNU_RAMP_DECEL 16'h009d
`define SMWM_PNU_ESTOP_DECEL 16'h009f
`define SMWM_PNU_CRUISE 16'h00a1
`define SMWM_PNU_POS_TRACK_BAND 16'h00a3
`define SMWM_PNU_POS_ARRIVAL_BAND 16'h00a5
`define SMWM_PNU_VEL_TRACK_BAND 16'h00a7
`define SMWM_PNU_OVERSPEED 16'h00a9
`define SMWM_PNU_VEL_ARRIVAL_BAND 16'h00ab
`define SMWM_PNU_STANDSTILL_LIMIT 16'h00ad
`define SMWM_PNU_TRACK_TIMEOUT 16'h00ae
`define SMWM_PNU_POS_DWELL 16'h00af
`define SMWM_PNU_STANDSTILL_DWELL 16'h00b0
`define SMWM_PNU_VEL_ERR_DWELL 16'h00b1
`define SMWM_PNU_VEL_DWELL 16'h00b2
`define SMWM_PNU_HOME_METHOD 16'h00b3
`define SMWM_PNU_HOME_OFFSET 16'h00b5
`define SMWM_ST_TARGET 10
`define SMWM_ST_STANDSTILL 12
`define SMWM_ST_TRACK_ERR 13
`define SMWM_HOME_MIN 9'sh181
`define SMWM_HOME_MAX 9'sh080
`define SMWM_MS_NS 1000000
`define SMWM_CLK_NS 10
`define SMWM_TMR_TRACK 0
`define SMWM_TMR_POS 1
`define SMWM_TMR_STAND 2
`define SMWM_TMR_VEL 3
`define SMWM_TMR_VERR 4
`define SMWM_NUM_TMR 5
`endif

// ===== rtl/smwm_pkg.sv
// Types shared by the motion window monitor modules
package smwm_pkg;
	`include "smwm_defines.svh"
	typedef logic [15:0] smwm_word_type;
	typedef logic [31:0] smwm_dword_type;
	typedef struct packed {
		logic [15:0] cnt;
		logic done;
	} smwm_timer_state_type;
	typedef struct packed {
		logic [`SMWM_REG_WORDS-1:0][15:0] regs;
		logic [16:0] tick_cnt;
		logic tick;
		logic stand;
		logic [15:0] rdata;
		logic ack;
		logic err;
		logic [15:0] status;
		logic [31:0] accel;
		logic [31:0] decel;
		logic [31:0] cruise;
		logic [31:0] speed;
		logic [31:0] zero;
		logic [31:0] abs_target;
		logic [8:0] home_method;
		logic overspeed;
		logic vel_err;
	} smwm_top_state_type;
endpackage

// ===== rtl/smwm_dwell_timer.sv
// Millisecond dwell timer that restarts whenever its condition drops
`timescale 1ns/100ps
module smwm_dwell_timer (
	input wire logic i_ref_clk, // 100 MHz clock
	input wire logic i_srst, // Sync reset, active high
	input wire logic i_tick, // One-millisecond pulse
	input wire logic i_cond, // Qualifying condition
	input wire smwm_pkg::smwm_word_type i_limit, // Dwell in milliseconds
	output logic o_done // Condition held for the dwell
);
	import smwm_pkg::*;
	smwm_timer_state_type q, d;

	always_comb begin
		d = q;
		if (!i_cond) begin
			d.cnt = 16'h0000;
		end else if (i_tick && q.cnt != i_limit) begin
			d.cnt = q.cnt + 16'h0001;
		end
		d.done = i_cond && (d.cnt >= i_limit);
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_done = q.done;

	property p_restart;
		@(posedge i_ref_clk) disable iff (i_srst)
		!i_cond |=> (q.cnt == 16'h0000) && !o_done;
	endproperty
	a_restart: assert property (p_restart) else $error("dwell timer did not restart");

	property p_no_early;
		@(posedge i_ref_clk) disable iff (i_srst)
		(i_cond && {1'b0, q.cnt} + 17'h00001 < {1'b0, i_limit} && !i_tick) |=> !o_done;
	endproperty
	a_no_early: assert property (p_no_early) else $error("dwell ended early");
endmodule

// ===== rtl/smwm_top.sv
// Motion parameter store and window supervision of a servo drive
`timescale 1ns/100ps
`include "smwm_defines.svh"
module smwm_top #(
	parameter int P_MS_CYCLES = `SMWM_MS_NS / `SMWM_CLK_NS // Clock cycles per millisecond
) (
	input wire logic i_ref_clk, // 100 MHz clock
	input wire logic i_srst, // Sync reset, active high
	input wire logic i_rec_wr, // Record word write strobe
	input wire logic i_rec_rd, // Record word read strobe
	input wire smwm_pkg::smwm_word_type i_rec_addr, // Parameter word number
	input wire smwm_pkg::smwm_word_type i_rec_wdata, // Write word
	input wire smwm_pkg::smwm_dword_type i_pos_cmd, // Commanded position, increments
	input wire smwm_pkg::smwm_dword_type i_pos_target, // Target position, increments
	input wire smwm_pkg::smwm_dword_type i_pos_meas, // Measured position, increments
	input wire smwm_pkg::smwm_dword_type i_vel_target, // Target velocity, increments/s
	input wire smwm_pkg::smwm_dword_type i_vel_meas, // Measured velocity, increments/s
	input wire smwm_pkg::smwm_dword_type i_speed_demand, // Speed demand before limit
	input wire smwm_pkg::smwm_dword_type i_move_target, // Absolute move target, user zero
	input wire smwm_pkg::smwm_dword_type i_home_found_pos, // Home position found
	input wire logic i_homing_done, // Homing finished pulse
	input wire logic i_vel_mode, // Velocity operation selected
	input wire logic i_quick_stop, // Quick-stop command level
	input wire smwm_pkg::smwm_dword_type i_pos_fac_num, // Position factor numerator
	input wire smwm_pkg::smwm_dword_type i_pos_fac_div, // Position factor divisor
	input wire smwm_pkg::smwm_dword_type i_vel_fac_num, // Velocity factor numerator
	input wire smwm_pkg::smwm_dword_type i_vel_fac_div, // Velocity factor divisor
	input wire smwm_pkg::smwm_dword_type i_acc_fac_num, // Acceleration factor numerator
	input wire smwm_pkg::smwm_dword_type i_acc_fac_div, // Acceleration factor divisor
	output smwm_pkg::smwm_word_type o_rec_rdata, // Read word
	output logic o_rec_ack, // Access answered pulse
	output logic o_rec_err, // Unmapped word pulse
	output smwm_pkg::smwm_word_type o_status, // Status bits 10, 12, 13
	output smwm_pkg::smwm_dword_type o_ramp_accel, // Ramp acceleration, scaled
	output smwm_pkg::smwm_dword_type o_ramp_decel, // Active deceleration, scaled
	output smwm_pkg::smwm_dword_type o_cruise_speed, // Cruise speed, scaled
	output smwm_pkg::smwm_dword_type o_speed_limited, // Clamped speed demand
	output smwm_pkg::smwm_dword_type o_zero_pos, // Application zero
	output smwm_pkg::smwm_dword_type o_abs_target, // Move target in increments
	output logic [8:0] o_home_method, // Signed homing selector
	output logic o_overspeed, // Speed above overspeed limit
	output logic o_vel_track_err // Velocity error held past dwell
);
	import smwm_pkg::*;

	smwm_top_state_type q, d;
	logic [`SMWM_NUM_TMR-1:0] tmr_cond;
	logic [`SMWM_NUM_TMR-1:0] tmr_done;
	logic [15:0] tmr_lim [`SMWM_NUM_TMR];
	logic [31:0] pos_fe_band, pos_arr_band, vel_arr_band, vel_err_band;
	logic [31:0] stand_lim, over_lim, max_inc, estop_inc;
	logic [32:0] pos_fe_mag, pos_arr_mag, vel_err_mag, vel_mag;
	logic signed [32:0] dem_s, max_s;
	logic signed [8:0] hm_s;
	logic [31:0] zero_sum;
	logic stand_below;
	logic [`SMWM_IDX_W-1:0] acc_idx;

	function automatic logic is_mapped(input logic [15:0] a);
		is_mapped = (a == `SMWM_PNU_THERMAL_TIME)
			|| (a >= `SMWM_PNU_LINES_REV && a <= `SMWM_PNU_MAX_SPEED + 16'h0001)
			|| (a >= `SMWM_PNU_RAMP_ACCEL && a <= `SMWM_PNU_HOME_METHOD)
			|| (a >= `SMWM_PNU_HOME_OFFSET && a <= `SMWM_PNU_HOME_OFFSET + 16'h0001);
	endfunction

	function automatic logic [`SMWM_IDX_W-1:0] word_idx(input logic [15:0] a);
		logic [15:0] off;
		off = a - `SMWM_REG_BASE;
		word_idx = off[`SMWM_IDX_W-1:0];
	endfunction

	// Low word at the named number, high word at the next
	function automatic logic [31:0] rd32(input logic [15:0] a);
		rd32 = {q.regs[word_idx(a + 16'h0001)], q.regs[word_idx(a)]};
	endfunction

	// Zero divisor leaves the value unscaled rather than producing garbage
	function automatic logic [31:0] conv(input logic [31:0] v, input logic [31:0] num,
		input logic [31:0] dv);
		logic [63:0] prod;
		logic [63:0] quo;
		prod = {32'h00000000, v} * {32'h00000000, num};
		quo = (dv == 32'h00000000) ? {32'h00000000, v} : prod / {32'h00000000, dv};
		conv = quo[31:0];
	endfunction

	function automatic logic [32:0] absdiff(input logic [31:0] a, input logic [31:0] b);
		logic signed [32:0] df;
		df = $signed({a[31], a}) - $signed({b[31], b});
		absdiff = df[32] ? 33'(-df) : 33'(df);
	endfunction

	always_comb begin
		pos_fe_band = conv(rd32(`SMWM_PNU_POS_TRACK_BAND), i_pos_fac_num, i_pos_fac_div);
		pos_arr_band = conv(rd32(`SMWM_PNU_POS_ARRIVAL_BAND), i_pos_fac_num, i_pos_fac_div);
		vel_arr_band = conv(rd32(`SMWM_PNU_VEL_ARRIVAL_BAND), i_vel_fac_num, i_vel_fac_div);
		vel_err_band = conv(rd32(`SMWM_PNU_VEL_TRACK_BAND), i_vel_fac_num, i_vel_fac_div);
		// Only the low word exists; the next number is the track timeout
		stand_lim = conv({16'h0000, q.regs[word_idx(`SMWM_PNU_STANDSTILL_LIMIT)]},
			i_vel_fac_num, i_vel_fac_div);
		over_lim = conv(rd32(`SMWM_PNU_OVERSPEED), i_vel_fac_num, i_vel_fac_div);
		max_inc = conv(rd32(`SMWM_PNU_MAX_SPEED), i_vel_fac_num, i_vel_fac_div);
		estop_inc = conv(rd32(`SMWM_PNU_ESTOP_DECEL), i_acc_fac_num, i_acc_fac_div);
		pos_fe_mag = absdiff(i_pos_meas, i_pos_cmd);
		pos_arr_mag = absdiff(i_pos_meas, i_pos_target);
		vel_err_mag = absdiff(i_vel_target, i_vel_meas);
		vel_mag = absdiff(i_vel_meas, 32'h00000000);
		stand_below = vel_mag < {1'b0, stand_lim};
		tmr_cond[`SMWM_TMR_TRACK] = pos_fe_mag > {1'b0, pos_fe_band};
		tmr_cond[`SMWM_TMR_POS] = pos_arr_mag <= {1'b0, pos_arr_band};
		tmr_cond[`SMWM_TMR_STAND] = vel_mag > {1'b0, stand_lim};
		tmr_cond[`SMWM_TMR_VEL] = vel_err_mag <= {1'b0, vel_arr_band};
		tmr_cond[`SMWM_TMR_VERR] = vel_err_mag > {1'b0, vel_err_band};
		tmr_lim[`SMWM_TMR_TRACK] = q.regs[word_idx(`SMWM_PNU_TRACK_TIMEOUT)];
		tmr_lim[`SMWM_TMR_POS] = q.regs[word_idx(`SMWM_PNU_POS_DWELL)];
		tmr_lim[`SMWM_TMR_STAND] = q.regs[word_idx(`SMWM_PNU_STANDSTILL_DWELL)];
		tmr_lim[`SMWM_TMR_VEL] = q.regs[word_idx(`SMWM_PNU_VEL_DWELL)];
		tmr_lim[`SMWM_TMR_VERR] = q.regs[word_idx(`SMWM_PNU_VEL_ERR_DWELL)];
		dem_s = $signed({i_speed_demand[31], i_speed_demand});
		max_s = $signed({1'b0, max_inc});
		hm_s = $signed(q.regs[word_idx(`SMWM_PNU_HOME_METHOD)][8:0]);
		zero_sum = i_home_found_pos + rd32(`SMWM_PNU_HOME_OFFSET);
		acc_idx = word_idx(i_rec_addr);
	end

	genvar g;
	generate
		for (g = 0; g < `SMWM_NUM_TMR; g++) begin : g_tmr
			smwm_dwell_timer u_tmr (
				.i_ref_clk(i_ref_clk),
				.i_srst(i_srst),
				.i_tick(q.tick),
				.i_cond(tmr_cond[g]),
				.i_limit(tmr_lim[g]),
				.o_done(tmr_done[g])
			);
		end
	endgenerate

	always_comb begin
		d = q;
		d.ack = 1'b0;
		d.err = 1'b0;
		// Record access; a write and a read in the same cycle both act, read data is the old word
		if (i_rec_wr || i_rec_rd) begin
			d.ack = 1'b1;
			if (is_mapped(i_rec_addr)) begin
				d.rdata = q.regs[acc_idx];
				if (i_rec_wr) begin
					d.regs[acc_idx] = i_rec_wdata;
				end
			end else begin
				d.err = 1'b1;
				d.rdata = 16'h0000;
			end
		end
		if (q.tick_cnt == 17'(P_MS_CYCLES - 1)) begin
			d.tick_cnt = 17'h00000;
			d.tick = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + 17'h00001;
			d.tick = 1'b0;
		end
		if (stand_below) begin
			d.stand = 1'b1;
		end else if (tmr_done[`SMWM_TMR_STAND]) begin
			d.stand = 1'b0;
		end
		d.status = 16'h0000;
		d.status[`SMWM_ST_TRACK_ERR] = tmr_done[`SMWM_TMR_TRACK];
		d.status[`SMWM_ST_STANDSTILL] = d.stand;
		d.status[`SMWM_ST_TARGET] = i_vel_mode ? tmr_done[`SMWM_TMR_VEL]
			: tmr_done[`SMWM_TMR_POS];
		d.vel_err = tmr_done[`SMWM_TMR_VERR];
		d.overspeed = vel_mag > {1'b0, over_lim};
		d.accel = conv(rd32(`SMWM_PNU_RAMP_ACCEL), i_acc_fac_num, i_acc_fac_div);
		// Quick stop overrides the profile ramp for as long as it is held
		d.decel = i_quick_stop
			? estop_inc
			: conv(rd32(`SMWM_PNU_RAMP_DECEL), i_acc_fac_num, i_acc_fac_div);
		d.cruise = conv(rd32(`SMWM_PNU_CRUISE), i_vel_fac_num, i_vel_fac_div);
		if (dem_s > max_s) begin
			d.speed = max_s[31:0];
		end else if (dem_s < -max_s) begin
			d.speed = 32'(-max_s);
		end else begin
			d.speed = i_speed_demand;
		end
		if (hm_s > `SMWM_HOME_MAX) begin
			d.home_method = `SMWM_HOME_MAX;
		end else if (hm_s < `SMWM_HOME_MIN) begin
			d.home_method = `SMWM_HOME_MIN;
		end else begin
			d.home_method = hm_s;
		end
		if (i_homing_done) begin
			d.zero = zero_sum;
		end
		d.abs_target = q.zero + i_move_target;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_srst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_rec_rdata = q.rdata;
	assign o_rec_ack = q.ack;
	assign o_rec_err = q.err;
	assign o_status = q.status;
	assign o_ramp_accel = q.accel;
	assign o_ramp_decel = q.decel;
	assign o_cruise_speed = q.cruise;
	assign o_speed_limited = q.speed;
	assign o_zero_pos = q.zero;
	assign o_abs_target = q.abs_target;
	assign o_home_method = q.home_method;
	assign o_overspeed = q.overspeed;
	assign o_vel_track_err = q.vel_err;

	sequence s_tick_gap;
		q.tick ##1 !q.tick [*8];
	endsequence

	property p_tick_gap;
		@(posedge i_ref_clk) disable iff (i_srst)
		q.tick |-> s_tick_gap;
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("millisecond ticks too close");

	property p_track_err;
		@(posedge i_ref_clk) disable iff (i_srst)
		tmr_done[`SMWM_TMR_TRACK] |=> o_status[`SMWM_ST_TRACK_ERR];
	endproperty
	a_track_err: assert property (p_track_err) else $error("bit 13 missed");

	property p_pos_reached;
		@(posedge i_ref_clk) disable iff (i_srst)
		(!i_vel_mode && !tmr_cond[`SMWM_TMR_POS]) ##1 !i_vel_mode
			|=> !o_status[`SMWM_ST_TARGET];
	endproperty
	a_pos_reached: assert property (p_pos_reached) else $error("bit 10 outside band");

	property p_pos_dwell;
		@(posedge i_ref_clk) disable iff (i_srst)
		(!i_vel_mode && tmr_done[`SMWM_TMR_POS]) |=> o_status[`SMWM_ST_TARGET];
	endproperty
	a_pos_dwell: assert property (p_pos_dwell) else $error("bit 10 not set");

	property p_vel_reached;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_vel_mode |=> o_status[`SMWM_ST_TARGET] == $past(tmr_done[`SMWM_TMR_VEL]);
	endproperty
	a_vel_reached: assert property (p_vel_reached) else $error("velocity bit 10 wrong");

	property p_stand_set;
		@(posedge i_ref_clk) disable iff (i_srst)
		stand_below |=> o_status[`SMWM_ST_STANDSTILL];
	endproperty
	a_stand_set: assert property (p_stand_set) else $error("bit 12 not set");

	property p_stand_clr;
		@(posedge i_ref_clk) disable iff (i_srst)
		(!stand_below && tmr_done[`SMWM_TMR_STAND]) |=> !o_status[`SMWM_ST_STANDSTILL];
	endproperty
	a_stand_clr: assert property (p_stand_clr) else $error("bit 12 not cleared");

	property p_speed_lim;
		@(posedge i_ref_clk) disable iff (i_srst)
		(dem_s > max_s) |=> o_speed_limited == $past(max_inc);
	endproperty
	a_speed_lim: assert property (p_speed_lim) else $error("speed not clamped");

	property p_zero;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_homing_done |=> o_zero_pos == $past(zero_sum);
	endproperty
	a_zero: assert property (p_zero) else $error("zero not home plus offset");

	property p_ack;
		@(posedge i_ref_clk) disable iff (i_srst)
		(i_rec_wr || i_rec_rd) |=> o_rec_ack ##1 !o_rec_ack || $past(i_rec_wr || i_rec_rd);
	endproperty
	a_ack: assert property (p_ack) else $error("record access not answered");

	property p_speed_neg;
		@(posedge i_ref_clk) disable iff (i_srst)
		(dem_s < -max_s) |=> o_speed_limited == 32'h00000000 - $past(max_inc);
	endproperty
	a_speed_neg: assert property (p_speed_neg) else $error("reverse speed not clamped");

	property p_home_range;
		@(posedge i_ref_clk) disable iff (i_srst)
		$signed(o_home_method) <= `SMWM_HOME_MAX
			&& $signed(o_home_method) >= `SMWM_HOME_MIN;
	endproperty
	a_home_range: assert property (p_home_range) else $error("homing selector out of range");

	property p_estop;
		@(posedge i_ref_clk) disable iff (i_srst)
		i_quick_stop |=> o_ramp_decel == $past(estop_inc);
	endproperty
	a_estop: assert property (p_estop) else $error("quick stop rate not applied");

	property p_unmapped;
		@(posedge i_ref_clk) disable iff (i_srst)
		((i_rec_wr || i_rec_rd) && !is_mapped(i_rec_addr))
			|=> o_rec_err && o_rec_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped word not refused");

	property p_wr_lands;
		@(posedge i_ref_clk) disable iff (i_srst)
		(i_rec_wr && is_mapped(i_rec_addr))
			|=> q.regs[$past(acc_idx)] == $past(i_rec_wdata);
	endproperty
	a_wr_lands: assert property (p_wr_lands) else $error("parameter word not stored");

	// Read data is a holding register, not a pulse
	property p_rdata_hold;
		@(posedge i_ref_clk) disable iff (i_srst)
		!(i_rec_wr || i_rec_rd) |=> $stable(o_rec_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read word changed");

	property p_abs_target;
		@(posedge i_ref_clk) disable iff (i_srst)
		1'b1 |=> o_abs_target == $past(q.zero) + $past(i_move_target);
	endproperty
	a_abs_target: assert property (p_abs_target) else $error("move not relative to zero");
endmodule

// ===== verification/smwm_rec_ctrl_model.sv
// Record controller model issuing parameter word accesses
`timescale 1ns/100ps
module smwm_rec_ctrl_model (
	input wire logic i_ref_clk, // Bench clock
	output logic o_rec_wr, // Write strobe
	output logic o_rec_rd, // Read strobe
	output smwm_pkg::smwm_word_type o_rec_addr, // Word number
	output smwm_pkg::smwm_word_type o_rec_wdata // Write word
);
	import smwm_pkg::*;
	initial begin
		o_rec_wr = 1'b0;
		o_rec_rd = 1'b0;
		o_rec_addr = 16'h0000;
		o_rec_wdata = 16'h0000;
	end
	// Strobe left up so accesses can run back to back
	task automatic access(input logic wr, input smwm_word_type a, input smwm_word_type d);
		@(negedge i_ref_clk);
		o_rec_wr = wr;
		o_rec_rd = ~wr;
		o_rec_addr = a;
		o_rec_wdata = d;
	endtask
	// Released lines show the inverse so stale values never look valid
	task automatic release_bus();
		@(negedge i_ref_clk);
		o_rec_wr = 1'b0;
		o_rec_rd = 1'b0;
		o_rec_addr = ~o_rec_addr;
		o_rec_wdata = ~o_rec_wdata;
	endtask
endmodule

// ===== verification/smwm_top_tb_top.sv
// Self-checking bench of the motion window monitor
`timescale 1ns/100ps
module smwm_top_tb_top;
	import smwm_pkg::*;
	localparam int P_MS = 10;
	typedef struct packed {logic err; logic [15:0] data;} smwm_note_type;
	logic i_ref_clk = 1'b0;
	logic i_srst = 1'b1;
	logic rec_wr, rec_rd, o_rec_ack, o_rec_err, o_overspeed, o_vel_err;
	logic homing_done = 1'b0;
	logic vel_mode = 1'b0;
	logic qstop = 1'b0;
	smwm_word_type rec_addr, rec_wdata, o_rec_rdata, o_status;
	smwm_dword_type pos_cmd = '0, pos_tgt = '0, pos_meas = '0, vel_tgt = '0, vel_meas = '0;
	smwm_dword_type speed_dem = '0, move_tgt = '0, home_pos = '0;
	smwm_dword_type pos_num = 1, pos_div = 1, vel_num = 1, vel_div = 1, acc_num = 1, acc_div = 1;
	smwm_dword_type o_accel, o_decel, o_cruise, o_speed, o_zero, o_abs, off;
	logic [8:0] o_home;
	logic [31:0] dem [4] = '{32'd5000, -32'sd5000, 32'd2999, -32'sd3001};
	logic [31:0] lim [4] = '{32'd3000, -32'sd3000, 32'd2999, -32'sd3000};
	logic [15:0] hm_in [6] = '{16'h0005, 16'h0080, 16'h01ff, 16'h0181, 16'h0180, 16'h00ff};
	logic [8:0] hm_exp [6] = '{9'h005, 9'h080, 9'h1ff, 9'h181, 9'h181, 9'h080};
	logic [15:0] shadow [16'h0090:16'h00b7] = '{default: 16'h0000};
	smwm_note_type exp_q[$];
	smwm_note_type note;
	int n_errors = 0;
	int check_count = 0;

	smwm_top #(.P_MS_CYCLES(P_MS)) u_smwm_top (
		.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_rec_wr(rec_wr), .i_rec_rd(rec_rd),
		.i_rec_addr(rec_addr), .i_rec_wdata(rec_wdata), .i_pos_cmd(pos_cmd),
		.i_pos_target(pos_tgt), .i_pos_meas(pos_meas), .i_vel_target(vel_tgt),
		.i_vel_meas(vel_meas), .i_speed_demand(speed_dem), .i_move_target(move_tgt),
		.i_home_found_pos(home_pos), .i_homing_done(homing_done), .i_vel_mode(vel_mode),
		.i_quick_stop(qstop), .i_pos_fac_num(pos_num), .i_pos_fac_div(pos_div),
		.i_vel_fac_num(vel_num), .i_vel_fac_div(vel_div), .i_acc_fac_num(acc_num),
		.i_acc_fac_div(acc_div), .o_rec_rdata(o_rec_rdata), .o_rec_ack(o_rec_ack),
		.o_rec_err(o_rec_err), .o_status(o_status), .o_ramp_accel(o_accel),
		.o_ramp_decel(o_decel), .o_cruise_speed(o_cruise), .o_speed_limited(o_speed),
		.o_zero_pos(o_zero), .o_abs_target(o_abs), .o_home_method(o_home),
		.o_overspeed(o_overspeed), .o_vel_track_err(o_vel_err));

	smwm_rec_ctrl_model u_smwm_rec_ctrl_model (.i_ref_clk(i_ref_clk), .o_rec_wr(rec_wr),
		.o_rec_rd(rec_rd), .o_rec_addr(rec_addr), .o_rec_wdata(rec_wdata));

	initial begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	function automatic logic mapped(input logic [15:0] a);
		return a == 16'h0091 || (a >= 16'h0095 && a <= 16'h0098) ||
			(a >= 16'h009b && a <= 16'h00b3) || a == 16'h00b5 || a == 16'h00b6;
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Expected answer noted before the access goes out
	task automatic rec(input logic wr, input logic [15:0] a, input logic [15:0] d);
		logic m;
		m = mapped(a);
		exp_q.push_back({~m, m ? shadow[a] : 16'h0000});
		if (wr && m) begin
			shadow[a] = d;
		end
		u_smwm_rec_ctrl_model.access(wr, a, d);
	endtask

	task automatic wr32(input logic [15:0] a, input logic [31:0] v);
		rec(1'b1, a, v[15:0]);
		rec(1'b1, a + 16'h0001, v[31:16]);
	endtask

	task automatic idle();
		u_smwm_rec_ctrl_model.release_bus();
		repeat (3) @(negedge i_ref_clk);
	endtask

	task automatic wait_bit(input int b, input logic v, input int lmt);
		int i;
		i = 0;
		while (o_status[b] !== v && i < lmt) begin
			@(negedge i_ref_clk);
			i++;
		end
		chk("status", {31'h0, o_status[b]}, {31'h0, v});
		if (o_status[b] !== v) begin
			final_report();
		end
	endtask

	task automatic hold_bit(input int b, input logic v, input int n);
		repeat (n) begin
			@(negedge i_ref_clk);
			chk("status hold", {31'h0, o_status[b]}, {31'h0, v});
		end
	endtask

	// Answer monitor: oldest note against each acknowledge
	always @(negedge i_ref_clk) begin
		if (i_srst === 1'b0 && o_rec_ack === 1'b1) begin
			note = exp_q.pop_front();
			chk("rec_rdata", {16'h0, o_rec_rdata}, {16'h0, note.data});
			chk("rec_err", {31'h0, o_rec_err}, {31'h0, note.err});
		end
	end

	initial begin
		repeat (100000) @(posedge i_ref_clk);
		n_errors++;
		final_report();
	end

	initial begin
		void'($urandom(8228));
		repeat (20) @(negedge i_ref_clk);
		i_srst = 1'b0;
		for (int a = 16'h0090; a <= 16'h00b7; a++) rec(1'b0, a[15:0], 16'h0000);
		for (int a = 16'h0090; a <= 16'h00b7; a++) rec(1'b1, a[15:0], 16'($urandom()));
		for (int a = 16'h0090; a <= 16'h00b7; a++) rec(1'b0, a[15:0], 16'h0000);
		// Standstill flag with a two millisecond dwell
		rec(1'b1, 16'h00ad, 16'd100);
		rec(1'b1, 16'h00b0, 16'd2);
		idle();
		wait_bit(12, 1'b1, 4);
		vel_meas = 32'd500;
		repeat (8) @(negedge i_ref_clk);
		vel_meas = -32'sd30;
		repeat (3) @(negedge i_ref_clk);
		vel_meas = -32'sd500;
		hold_bit(12, 1'b1, P_MS - 1);
		wait_bit(12, 1'b0, 4 * P_MS);
		vel_meas = -32'sd50;
		wait_bit(12, 1'b1, 4);
		vel_meas = 32'd150;
		hold_bit(12, 1'b1, P_MS - 1);
		// Following error band scaled by two
		pos_num = 32'd2;
		wr32(16'h00a3, 32'd25);
		rec(1'b1, 16'h00ae, 16'd3);
		idle();
		pos_cmd = 32'd1000;
		pos_meas = 32'd1050;
		hold_bit(13, 1'b0, 6 * P_MS);
		pos_meas = 32'd949;
		hold_bit(13, 1'b0, 2 * P_MS - 1);
		wait_bit(13, 1'b1, 5 * P_MS);
		pos_meas = 32'd1000;
		wait_bit(13, 1'b0, 4);
		pos_num = 32'd1;
		// Position arrival window
		wr32(16'h00a5, 32'd10);
		rec(1'b1, 16'h00af, 16'd2);
		idle();
		pos_tgt = 32'd2000;
		pos_meas = 32'd2011;
		wait_bit(10, 1'b0, 4 * P_MS);
		pos_meas = 32'd1990;
		hold_bit(10, 1'b0, P_MS - 1);
		wait_bit(10, 1'b1, 4 * P_MS);
		pos_meas = 32'd2011;
		wait_bit(10, 1'b0, 4);
		// Velocity arrival window overrides position
		pos_meas = 32'd2000;
		wr32(16'h00ab, 32'd20);
		rec(1'b1, 16'h00b2, 16'd1);
		idle();
		vel_mode = 1'b1;
		vel_tgt = 32'd300;
		vel_meas = 32'd250;
		wait_bit(10, 1'b0, 4 * P_MS);
		vel_meas = 32'd320;
		wait_bit(10, 1'b1, 3 * P_MS);
		vel_meas = 32'd279;
		wait_bit(10, 1'b0, 4);
		vel_mode = 1'b0;
		// Scaled ramps, cruise and speed clamp
		acc_num = 32'd3;
		acc_div = 32'd2;
		vel_num = 32'd3;
		wr32(16'h009b, 32'd100);
		wr32(16'h009d, 32'd40);
		wr32(16'h009f, 32'd80);
		wr32(16'h00a1, 32'd200);
		wr32(16'h0097, 32'd1000);
		idle();
		chk("accel", o_accel, 32'd150);
		chk("decel", o_decel, 32'd60);
		chk("cruise", o_cruise, 32'd600);
		qstop = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		chk("quick stop decel", o_decel, 32'd120);
		qstop = 1'b0;
		for (int k = 0; k < 5; k++) begin
			speed_dem = (k < 4) ? dem[k] : $urandom_range(2999, 0);
			repeat (3) @(negedge i_ref_clk);
			chk("speed", o_speed, (k < 4) ? lim[k] : speed_dem);
		end
		// Overspeed and velocity tracking flags, limits scaled by three
		wr32(16'h00a9, 32'd100);
		wr32(16'h00a7, 32'd10);
		rec(1'b1, 16'h00b1, 16'd1);
		vel_tgt = 32'd300;
		vel_meas = 32'd300;
		idle();
		chk("overspeed", {31'h0, o_overspeed}, 32'd0);
		chk("vel track err", {31'h0, o_vel_err}, 32'd0);
		vel_meas = -32'sd301;
		repeat (2) @(negedge i_ref_clk);
		chk("overspeed", {31'h0, o_overspeed}, 32'd1);
		repeat (P_MS + 2) @(negedge i_ref_clk);
		chk("vel track err", {31'h0, o_vel_err}, 32'd1);
		// Homing selector clamp, offset and new zero
		for (int k = 0; k < 6; k++) begin
			rec(1'b1, 16'h00b3, hm_in[k]);
			idle();
			chk("home method", {23'h0, o_home}, {23'h0, hm_exp[k]});
		end
		off = $urandom();
		wr32(16'h00b5, off);
		rec(1'b0, 16'h00b5, 16'h0000);
		rec(1'b0, 16'h00b6, 16'h0000);
		idle();
		home_pos = $urandom();
		homing_done = 1'b1;
		@(negedge i_ref_clk);
		homing_done = 1'b0;
		move_tgt = $urandom();
		repeat (3) @(negedge i_ref_clk);
		chk("zero", o_zero, home_pos + off);
		chk("abs target", o_abs, home_pos + off + move_tgt);
		chk("pending notes", 32'(exp_q.size()), 32'd0);
		final_report();
	end
endmodule
